// [core/opdec_top.sv]
// move, stack and branch opcode decoder with cycle counts
// Notes on behaviour
// - group 01 with a register source copies to a register in 4 cycles, or to memory 110 in 7.
// - group 01 with source 110 and a register destination loads it from memory at H&L in 7 cycles.
// - 00PP0001 loads a 16-bit immediate into B&C, D&E, H&L or the stack pointer in 10 cycles.
// - 11101011 swaps D&E with H&L in 4 cycles.
// - 11PP0101 with PP naming B&C, D&E or H&L pushes that pair in 12 cycles.
// - 11110101 pushes the accumulator and flags in 12 cycles.
// - 11PP0001 with PP naming B&C, D&E or H&L pops into that pair in 10 cycles.
// - 11110001 pops into the flags and accumulator in 10 cycles.
// - 11100011 swaps the stack top with H&L in 16 cycles.
// - 11111001 copies H&L into the stack pointer in 6 cycles.
// - 11101001 copies H&L into the program counter in 6 cycles.
`timescale 1ns/1ns
`default_nettype none
`include "opdec_params.svh"
module opdec_top
  import opdec_pkg::*;
(
  input  wire logic              I_CLK,
  input  wire logic              I_SYS_RST,
  input  wire logic              i_OPCODE_VALID,
  input  wire logic [7:0]        i_OPCODE,
  input  wire logic              i_FLAG_ZERO,
  input  wire logic              i_FLAG_CARRY,
  input  wire logic              i_FLAG_PARITY,
  input  wire logic              i_FLAG_SIGN,
  output logic                   o_DECODE_VALID,
  output opdec_pkg::op_class_t   o_OP_CLASS,
  output logic [4:0]             o_CYCLES,
  output logic [2:0]             o_DEST,
  output logic [2:0]             o_SRC,
  output logic [1:0]             o_PAIR,
  output logic                   o_TAKEN,
  output logic                   o_KNOWN
);
  import opdec_pkg::*;

  dec_state_t state_q;
  dec_state_t state_d;
  logic       cond_met;
  logic       is_cond_code;
  logic [1:0] grp;
  logic [2:0] dest_field;
  logic [2:0] source_field;
  logic [1:0] pair_field;

  function automatic logic is_mem(input logic [2:0] f);
    is_mem = (f == `REG_MEM);
  endfunction : is_mem

  assign grp          = i_OPCODE[`GRP_MSB:`GRP_LSB];
  assign dest_field   = i_OPCODE[`DEST_MSB:`DEST_LSB];
  assign source_field = i_OPCODE[`SRC_MSB:`SRC_LSB];
  assign pair_field   = i_OPCODE[`PAIR_MSB:`PAIR_LSB];
  assign is_cond_code = (grp == `GRP_HIGH) &&
                        (source_field == `LO3_BRANCH_CC || source_field == `LO3_CALL_CC);

  // condition evaluation for conditional jumps and calls
  opdec_cond_eval u_cond (
    .i_cond_code   (is_cond_code),
    .i_cond        (dest_field),
    .i_zero        (i_FLAG_ZERO),
    .i_carry       (i_FLAG_CARRY),
    .i_parity_even (i_FLAG_PARITY),
    .i_sign        (i_FLAG_SIGN),
    .o_met         (cond_met)
  );

  always_comb
  begin
    state_d          = state_q;
    state_d.valid    = i_OPCODE_VALID;
    if (i_OPCODE_VALID)
    begin
      state_d.op_class = OP_NONE;
      state_d.cycles   = `CYC_NONE;
      state_d.dest     = dest_field;
      state_d.src      = source_field;
      state_d.pair     = pair_field;
      state_d.taken    = 1'b0;
      state_d.known    = 1'b1;
      if (grp == `GRP_COPY)
      begin
        if (is_mem(source_field) && is_mem(dest_field))
        begin
          state_d.known = 1'b0;
        end
        else if (is_mem(source_field))
        begin
          state_d.op_class = OP_LOAD_MEM;
          state_d.cycles   = `CYC_LOAD_MEM;
        end
        else if (is_mem(dest_field))
        begin
          state_d.op_class = OP_STORE_MEM;
          state_d.cycles   = `CYC_STORE_MEM;
        end
        else
        begin
          state_d.op_class = OP_COPY_REG;
          state_d.cycles   = `CYC_COPY_REG;
        end
      end
      else if (grp == `GRP_LOW && source_field == `LO3_IMM)
      begin
        state_d.op_class = is_mem(dest_field) ? OP_COPY_IMM_MEM : OP_COPY_IMM_REG;
        state_d.cycles   = is_mem(dest_field) ? `CYC_IMM_MEM : `CYC_IMM_REG;
      end
      else if (grp == `GRP_LOW && i_OPCODE[3:0] == `LO4_PAIR_IMM)
      begin
        state_d.op_class = OP_LOAD_PAIR_IMM;
        state_d.cycles   = `CYC_PAIR_IMM;
      end
      else if (i_OPCODE == `OPC_SWAP_PAIRS)
      begin
        state_d.op_class = OP_SWAP_PAIRS;
        state_d.cycles   = `CYC_SWAP_PAIRS;
      end
      else if (i_OPCODE == `OPC_SWAP_STACK)
      begin
        state_d.op_class = OP_SWAP_STACK_TOP;
        state_d.cycles   = `CYC_SWAP_STACK;
      end
      else if (i_OPCODE == `OPC_LOAD_SP)
      begin
        state_d.op_class = OP_LOAD_SP;
        state_d.cycles   = `CYC_LOAD_SP;
      end
      else if (i_OPCODE == `OPC_LOAD_PC)
      begin
        state_d.op_class = OP_LOAD_PC;
        state_d.cycles   = `CYC_LOAD_PC;
      end
      else if (i_OPCODE == `OPC_BRANCH)
      begin
        state_d.op_class = OP_BRANCH;
        state_d.cycles   = `CYC_BRANCH;
        state_d.taken    = 1'b1;
      end
      else if (i_OPCODE == `OPC_CALL)
      begin
        state_d.op_class = OP_CALL;
        state_d.cycles   = `CYC_CALL;
        state_d.taken    = 1'b1;
      end
      else if (grp == `GRP_HIGH && i_OPCODE[3:0] == `LO4_PUSH)
      begin
        if (pair_field == `PAIR_SP_AF)
        begin
          state_d.op_class = OP_PUSH_ACC_FLAGS;
        end
        else
        begin
          state_d.op_class = OP_PUSH_PAIR;
        end
        state_d.cycles = `CYC_PUSH;
      end
      else if (grp == `GRP_HIGH && i_OPCODE[3:0] == `LO4_POP)
      begin
        if (pair_field == `PAIR_SP_AF)
        begin
          state_d.op_class = OP_POP_ACC_FLAGS;
        end
        else
        begin
          state_d.op_class = OP_POP_PAIR;
        end
        state_d.cycles = `CYC_POP;
      end
      else if (grp == `GRP_HIGH && source_field == `LO3_BRANCH_CC)
      begin
        state_d.op_class = OP_BRANCH_COND;
        state_d.taken    = cond_met;
        state_d.cycles   = cond_met ? `CYC_BRANCH : `CYC_BRANCH_NOT;
      end
      else if (grp == `GRP_HIGH && source_field == `LO3_CALL_CC)
      begin
        state_d.op_class = OP_CALL_COND;
        state_d.taken    = cond_met;
        state_d.cycles   = cond_met ? `CYC_CALL : `CYC_CALL_NOT;
      end
      else
      begin
        state_d.known = 1'b0;
      end
    end
  end

  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      state_q <= '{valid: 1'b0, op_class: OP_NONE, cycles: 5'h0, dest: 3'h0,
                   src: 3'h0, pair: 2'h0, taken: 1'b0, known: 1'b0};
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign o_DECODE_VALID = state_q.valid;
  assign o_OP_CLASS     = state_q.op_class;
  assign o_CYCLES       = state_q.cycles;
  assign o_DEST         = state_q.dest;
  assign o_SRC          = state_q.src;
  assign o_PAIR         = state_q.pair;
  assign o_TAKEN        = state_q.taken;
  assign o_KNOWN        = state_q.known;

  // checks on the decoded result one cycle after the opcode
  property p_copy_reg;
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (i_OPCODE_VALID && i_OPCODE[7:6] == 2'h1 && i_OPCODE[5:3] != 3'h6 && i_OPCODE[2:0] != 3'h6)
    |=> (o_OP_CLASS == OP_COPY_REG && o_CYCLES == 5'h4 && o_DEST == $past(i_OPCODE[5:3]));
  endproperty
  a_copy_reg: assert property (p_copy_reg) else $error("register copy misdecoded");

  property p_store_mem;
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (i_OPCODE_VALID && i_OPCODE[7:3] == 5'h0e && i_OPCODE[2:0] != 3'h6)
    |=> (o_OP_CLASS == OP_STORE_MEM && o_CYCLES == 5'h7);
  endproperty
  a_store_mem: assert property (p_store_mem) else $error("memory store misdecoded");

  property p_load_mem;
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (i_OPCODE_VALID && i_OPCODE[7:6] == 2'h1 && i_OPCODE[2:0] == 3'h6 && i_OPCODE[5:3] != 3'h6)
    |=> (o_OP_CLASS == OP_LOAD_MEM && o_CYCLES == 5'h7);
  endproperty
  a_load_mem: assert property (p_load_mem) else $error("memory load misdecoded");

  property p_pair_imm;
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (i_OPCODE_VALID && i_OPCODE[7:6] == 2'h0 && i_OPCODE[3:0] == 4'h1)
    |=> (o_OP_CLASS == OP_LOAD_PAIR_IMM && o_CYCLES == 5'ha && o_PAIR == $past(i_OPCODE[5:4]));
  endproperty
  a_pair_imm: assert property (p_pair_imm) else $error("pair immediate misdecoded");

  property p_swap_pairs;
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (i_OPCODE_VALID && i_OPCODE == 8'heb) |=> (o_OP_CLASS == OP_SWAP_PAIRS && o_CYCLES == 5'h4);
  endproperty
  a_swap_pairs: assert property (p_swap_pairs) else $error("pair swap misdecoded");

  property p_push;
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (i_OPCODE_VALID && i_OPCODE[7:6] == 2'h3 && i_OPCODE[3:0] == 4'h5)
    |=> (o_CYCLES == 5'hc && (o_OP_CLASS == OP_PUSH_ACC_FLAGS) == (o_PAIR == 2'h3));
  endproperty
  a_push: assert property (p_push) else $error("push misdecoded");

  property p_pop_acc;
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (i_OPCODE_VALID && i_OPCODE == 8'hf1) |=> (o_OP_CLASS == OP_POP_ACC_FLAGS && o_CYCLES == 5'ha);
  endproperty
  a_pop_acc: assert property (p_pop_acc) else $error("flag pop misdecoded");

  property p_pop_pair;
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (i_OPCODE_VALID && i_OPCODE[7:6] == 2'h3 && i_OPCODE[5:4] != 2'h3 && i_OPCODE[3:0] == 4'h1)
    |=> (o_OP_CLASS == OP_POP_PAIR && o_CYCLES == 5'ha && o_PAIR == $past(i_OPCODE[5:4]));
  endproperty
  a_pop_pair: assert property (p_pop_pair) else $error("pair pop misdecoded");

  property p_load_pc;
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (i_OPCODE_VALID && i_OPCODE == 8'he9) |=> (o_OP_CLASS == OP_LOAD_PC && o_CYCLES == 5'h6);
  endproperty
  a_load_pc: assert property (p_load_pc) else $error("program counter load misdecoded");

  property p_swap_stack;
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (i_OPCODE_VALID && i_OPCODE == 8'he3) |=> (o_OP_CLASS == OP_SWAP_STACK_TOP && o_CYCLES == 5'h10);
  endproperty
  a_swap_stack: assert property (p_swap_stack) else $error("stack swap misdecoded");

  property p_hl_loads;
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (i_OPCODE_VALID && (i_OPCODE == 8'hf9 || i_OPCODE == 8'he9)) |=> (o_CYCLES == 5'h6);
  endproperty
  a_hl_loads: assert property (p_hl_loads) else $error("pointer load misdecoded");

  property p_cond_cycles;
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (o_DECODE_VALID && (o_OP_CLASS == OP_BRANCH_COND || o_OP_CLASS == OP_CALL_COND))
    |-> (o_CYCLES == (o_OP_CLASS == OP_BRANCH_COND ? (o_TAKEN ? 5'ha : 5'h7) : (o_TAKEN ? 5'h12 : 5'h9)));
  endproperty
  a_cond_cycles: assert property (p_cond_cycles) else $error("conditional cycle count wrong");

  property p_zero_cond;
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (i_OPCODE_VALID && i_OPCODE == 8'hca) |=> (o_TAKEN == $past(i_FLAG_ZERO));
  endproperty
  a_zero_cond: assert property (p_zero_cond) else $error("zero condition wrong");

  property p_call;
    @(posedge I_CLK) disable iff (I_SYS_RST)
    (i_OPCODE_VALID && i_OPCODE == 8'hcd) |=> (o_OP_CLASS == OP_CALL && o_CYCLES == 5'h12 && o_TAKEN);
  endproperty
  a_call: assert property (p_call) else $error("call misdecoded");

  property p_valid_follows;
    @(posedge I_CLK) disable iff (I_SYS_RST)
    i_OPCODE_VALID |=> o_DECODE_VALID ##1 (o_DECODE_VALID == $past(i_OPCODE_VALID));
  endproperty
  a_valid_follows: assert property (p_valid_follows) else $error("decode strobe misplaced");

  c_call_taken: cover property (@(posedge I_CLK) o_DECODE_VALID && o_OP_CLASS == OP_CALL_COND && o_TAKEN);
  c_branch_skip: cover property (@(posedge I_CLK) o_DECODE_VALID && o_OP_CLASS == OP_BRANCH_COND && !o_TAKEN);
  c_push_flags: cover property (@(posedge I_CLK) o_DECODE_VALID && o_OP_CLASS == OP_PUSH_ACC_FLAGS);
  c_unknown: cover property (@(posedge I_CLK) o_DECODE_VALID && !o_KNOWN);

endmodule : opdec_top
`default_nettype wire

// [core/opdec_params.svh]
// opcode patterns, field positions and cycle counts of the move, stack and branch decoder
`ifndef OPDEC_PARAMS_SVH
`define OPDEC_PARAMS_SVH

// field positions inside the opcode byte
`define GRP_MSB        7
`define GRP_LSB        6
`define DEST_MSB       5
`define DEST_LSB       3
`define SRC_MSB        2
`define SRC_LSB        0
`define PAIR_MSB       5
`define PAIR_LSB       4

// field codes
`define GRP_COPY       2'h1
`define GRP_LOW        2'h0
`define GRP_HIGH       2'h3
`define REG_MEM        3'h6
`define PAIR_SP_AF     2'h3

// whole-byte opcodes
`define OPC_SWAP_PAIRS 8'heb
`define OPC_SWAP_STACK 8'he3
`define OPC_LOAD_SP    8'hf9
`define OPC_LOAD_PC    8'he9
`define OPC_BRANCH     8'hc3
`define OPC_CALL       8'hcd

// low-bit patterns
`define LO4_PAIR_IMM   4'h1
`define LO4_PUSH       4'h5
`define LO4_POP        4'h1
`define LO3_IMM        3'h6
`define LO3_BRANCH_CC  3'h2
`define LO3_CALL_CC    3'h4

// clock cycles per operation
`define CYC_COPY_REG    5'd4
`define CYC_STORE_MEM   5'd7
`define CYC_LOAD_MEM    5'd7
`define CYC_IMM_REG     5'd7
`define CYC_IMM_MEM     5'd10
`define CYC_PAIR_IMM    5'd10
`define CYC_SWAP_PAIRS  5'd4
`define CYC_PUSH        5'd12
`define CYC_POP         5'd10
`define CYC_SWAP_STACK  5'd16
`define CYC_LOAD_SP     5'd6
`define CYC_LOAD_PC     5'd6
`define CYC_BRANCH      5'd10
`define CYC_BRANCH_NOT  5'd7
`define CYC_CALL        5'd18
`define CYC_CALL_NOT    5'd9
`define CYC_NONE        5'd0

`endif

// [core/opdec_pkg.sv]
// types shared by the opcode decoder files
package opdec_pkg;

  typedef enum logic [4:0] {
    OP_NONE,
    OP_COPY_REG,
    OP_STORE_MEM,
    OP_LOAD_MEM,
    OP_COPY_IMM_REG,
    OP_COPY_IMM_MEM,
    OP_LOAD_PAIR_IMM,
    OP_SWAP_PAIRS,
    OP_PUSH_PAIR,
    OP_PUSH_ACC_FLAGS,
    OP_POP_PAIR,
    OP_POP_ACC_FLAGS,
    OP_SWAP_STACK_TOP,
    OP_LOAD_SP,
    OP_LOAD_PC,
    OP_BRANCH,
    OP_BRANCH_COND,
    OP_CALL,
    OP_CALL_COND
  } op_class_t;

  typedef enum logic [2:0] {
    CC_NO_ZERO,
    CC_ZERO,
    CC_NO_CARRY,
    CC_CARRY,
    CC_PARITY_ODD,
    CC_PARITY_EVEN,
    CC_POSITIVE,
    CC_MINUS
  } cond_t;

  typedef struct packed {
    logic      valid;
    op_class_t op_class;
    logic [4:0] cycles;
    logic [2:0] dest;
    logic [2:0] src;
    logic [1:0] pair;
    logic      taken;
    logic      known;
  } dec_state_t;

endpackage : opdec_pkg

// [core/opdec_cond_eval.sv]
// condition field evaluation against the processor flags
`timescale 1ns/1ns
`default_nettype none
module opdec_cond_eval
  import opdec_pkg::*;
(
  input  wire logic       i_cond_code,
  input  wire logic [2:0] i_cond,
  input  wire logic       i_zero,
  input  wire logic       i_carry,
  input  wire logic       i_parity_even,
  input  wire logic       i_sign,
  output logic            o_met
);
  import opdec_pkg::*;

  cond_t cond;

  always_comb
  begin
    cond  = cond_t'(i_cond);
    o_met = 1'b0;
    unique case (cond)
      CC_NO_ZERO:     o_met = ~i_zero;
      CC_ZERO:        o_met = i_zero;
      CC_NO_CARRY:    o_met = ~i_carry;
      CC_CARRY:       o_met = i_carry;
      CC_PARITY_ODD:  o_met = ~i_parity_even;
      CC_PARITY_EVEN: o_met = i_parity_even;
      CC_POSITIVE:    o_met = ~i_sign;
      CC_MINUS:       o_met = i_sign;
    endcase
    if (!i_cond_code)
    begin
      o_met = 1'b0;
    end
  end

endmodule : opdec_cond_eval
`default_nettype wire

// [test/opdec_prog_mem.sv]
// program memory model that hands opcode bytes to the decoder
`timescale 1ns/1ns
`default_nettype none
module opdec_prog_mem
(
  input  wire logic       i_clk,
  input  wire logic       i_fetch,
  input  wire logic [7:0] i_addr,
  output logic            o_valid,
  output logic [7:0]      o_opcode
);
  logic [7:0] mem_q [256];
  logic [7:0] junk_q = 8'h5a;
  // a released bus shows the inverse of the last byte, new every cycle
  always @(posedge i_clk)
  begin
    junk_q <= ~o_opcode;
  end
  assign o_valid  = i_fetch;
  assign o_opcode = i_fetch ? mem_q[i_addr] : junk_q;
  task automatic write_byte(input logic [7:0] a, input logic [7:0] b);
    mem_q[a] = b;
  endtask : write_byte
endmodule : opdec_prog_mem
`default_nettype wire

// [test/move_stack_branch_opcode_decoder_tb_top.sv]
// self-checking bench for the move, stack and branch opcode decoder
`timescale 1ns/1ns
`default_nettype none
module move_stack_branch_opcode_decoder_tb_top;
  import opdec_pkg::*;
  logic       clk_sys = 1'b0;
  logic       rst_sys = 1'b1;
  logic       fetch   = 1'b0;
  logic [7:0] pc      = 8'h00;
  logic [3:0] flg     = 4'h0;
  logic       mem_valid;
  logic [7:0] mem_opcode;
  logic       dec_valid;
  op_class_t  dec_class;
  logic [4:0] dec_cycles;
  logic [2:0] dec_dest;
  logic [2:0] dec_src;
  logic [1:0] dec_pair;
  logic       dec_taken;
  logic       dec_known;
  int         errors = 0;
  int         samples_checked = 0;
  logic       pend = 1'b0;
  logic [7:0] pend_op;
  op_class_t  pend_class;
  logic [4:0] pend_cyc;
  logic       pend_taken;

  always #10 clk_sys = ~clk_sys;

  opdec_prog_mem mem (.i_clk(clk_sys), .i_fetch(fetch), .i_addr(pc), .o_valid(mem_valid), .o_opcode(mem_opcode));
  opdec_top DUT (.I_CLK(clk_sys), .I_SYS_RST(rst_sys), .i_OPCODE_VALID(mem_valid), .i_OPCODE(mem_opcode),
    .i_FLAG_ZERO(flg[0]), .i_FLAG_CARRY(flg[1]), .i_FLAG_PARITY(flg[2]), .i_FLAG_SIGN(flg[3]),
    .o_DECODE_VALID(dec_valid), .o_OP_CLASS(dec_class), .o_CYCLES(dec_cycles), .o_DEST(dec_dest),
    .o_SRC(dec_src), .o_PAIR(dec_pair), .o_TAKEN(dec_taken), .o_KNOWN(dec_known));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  task automatic verify_pending();
    if (pend)
    begin
      check("decode_valid", {7'h0, dec_valid}, 8'h01);
      check("op_class", {3'h0, dec_class}, {3'h0, pend_class});
      check("cycles", {3'h0, dec_cycles}, {3'h0, pend_cyc});
      check("taken", {7'h0, dec_taken}, {7'h0, pend_taken});
      check("known", {7'h0, dec_known}, {7'h0, pend_class != OP_NONE});
      check("fields", {dec_dest, dec_src, dec_pair}, {pend_op[5:3], pend_op[2:0], pend_op[5:4]});
    end
  endtask : verify_pending

  // present one opcode; the previous one is judged at the same edge
  task automatic send(input logic [7:0] op, input logic [3:0] f, input op_class_t c, input logic [4:0] cyc,
                      input logic tk);
    @(negedge clk_sys);
    verify_pending();
    pc = pc + 8'h01;
    mem.write_byte(pc, op);
    flg = f;
    fetch = 1'b1;
    pend = 1'b1;
    pend_op = op;
    pend_class = c;
    pend_cyc = cyc;
    pend_taken = tk;
  endtask : send

  task automatic settle(input string name);
    @(negedge clk_sys);
    verify_pending();
    pend = 1'b0;
    fetch = 1'b0;
    @(negedge clk_sys);
    check("valid_drop", {7'h0, dec_valid}, 8'h00);
    check("class_held", {3'h0, dec_class}, {3'h0, pend_class});
    $display("test %s done, mismatches %0d", name, errors);
  endtask : settle

  task automatic check_cleared();
    check("clear_valid", {7'h0, dec_valid}, 8'h00);
    check("clear_class", {3'h0, dec_class}, 8'h00);
    check("clear_cycles", {3'h0, dec_cycles}, 8'h00);
    check("clear_fields", {dec_dest, dec_src, dec_pair}, 8'h00);
    check("clear_flags", {6'h0, dec_taken, dec_known}, 8'h00);
  endtask : check_cleared

  task automatic t_moves();
    logic [7:0] op;
    for (int i = 0; i < 64; i++)
    begin
      op = 8'h40 | 8'(i);
      if (op == 8'h76) send(op, 4'h0, OP_NONE, 5'd0, 1'b0);
      else if (op[2:0] == 3'h6) send(op, 4'h0, OP_LOAD_MEM, 5'd7, 1'b0);
      else if (op[5:3] == 3'h6) send(op, 4'h0, OP_STORE_MEM, 5'd7, 1'b0);
      else send(op, 4'h0, OP_COPY_REG, 5'd4, 1'b0);
    end
    settle("moves");
  endtask : t_moves

  task automatic t_pairs_stack();
    for (int p = 0; p < 4; p++)
    begin
      send({2'h0, 2'(p), 4'h1}, 4'h0, OP_LOAD_PAIR_IMM, 5'd10, 1'b0);
      send({2'h3, 2'(p), 4'h5}, 4'h0, p == 3 ? OP_PUSH_ACC_FLAGS : OP_PUSH_PAIR, 5'd12, 1'b0);
      send({2'h3, 2'(p), 4'h1}, 4'h0, p == 3 ? OP_POP_ACC_FLAGS : OP_POP_PAIR, 5'd10, 1'b0);
    end
    for (int d = 0; d < 8; d++)
      send({2'h0, 3'(d), 3'h6}, 4'h0, d == 6 ? OP_COPY_IMM_MEM : OP_COPY_IMM_REG, d == 6 ? 5'd10 : 5'd7, 1'b0);
    settle("pairs_stack");
  endtask : t_pairs_stack

  task automatic t_whole_bytes();
    send(8'heb, 4'h0, OP_SWAP_PAIRS, 5'd4, 1'b0);
    send(8'he3, 4'h0, OP_SWAP_STACK_TOP, 5'd16, 1'b0);
    send(8'hf9, 4'h0, OP_LOAD_SP, 5'd6, 1'b0);
    send(8'he9, 4'h0, OP_LOAD_PC, 5'd6, 1'b0);
    send(8'hc3, 4'h0, OP_BRANCH, 5'd10, 1'b1);
    send(8'hcd, 4'hf, OP_CALL, 5'd18, 1'b1);
    send(8'hc9, 4'h0, OP_NONE, 5'd0, 1'b0);
    send(8'h80, 4'h0, OP_NONE, 5'd0, 1'b0);
    settle("whole_bytes");
  endtask : t_whole_bytes

  // the selected flag differs from all the others in each case
  task automatic t_conditions();
    logic [3:0] f;
    logic       tk;
    for (int cc = 0; cc < 8; cc++)
      for (int v = 0; v < 2; v++)
      begin
        f = 4'h1 << cc[2:1];
        f = v[0] ? f : ~f;
        tk = cc[0] ? v[0] : !v[0];
        send({2'h3, 3'(cc), 3'h2}, f, OP_BRANCH_COND, tk ? 5'd10 : 5'd7, tk);
        send({2'h3, 3'(cc), 3'h4}, f, OP_CALL_COND, tk ? 5'd18 : 5'd9, tk);
      end
    settle("conditions");
  endtask : t_conditions

  task automatic t_mid_reset();
    send(8'hcd, 4'h0, OP_CALL, 5'd18, 1'b1);
    @(negedge clk_sys);
    verify_pending();
    pend = 1'b0;
    fetch = 1'b0;
    rst_sys = 1'b1;
    #1;
    check_cleared();
    @(negedge clk_sys);
    rst_sys = 1'b0;
    @(negedge clk_sys);
    check_cleared();
    send(8'h78, 4'h0, OP_COPY_REG, 5'd4, 1'b0);
    settle("mid_reset");
  endtask : t_mid_reset

  initial
  begin
    #200000;
    errors++;
    $display("timeout waiting for the run to end");
    report_and_stop();
  end

  initial
  begin
    repeat (5) @(negedge clk_sys);
    rst_sys = 1'b0;
    @(negedge clk_sys);
    check_cleared();
    t_moves();
    t_pairs_stack();
    t_whole_bytes();
    t_conditions();
    t_mid_reset();
    report_and_stop();
  end
endmodule : move_stack_branch_opcode_decoder_tb_top
`default_nettype wire
